/* File: irte_consts.svh */
/*
  constants for the interrupt-return epilogue unit: register offsets,
  field positions, reset values and stack offsets.
  assumes it is included once per compilation unit by its bare name.
*/
`ifndef IRTE_CONSTS_SVH
`define IRTE_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IRTE_OFF_INT_CTRL 8'h00
`define IRTE_OFF_STATUS 8'h04
`define IRTE_OFF_SRS_CTRL 8'h08
`define IRTE_OFF_EPC 8'h0C
`define IRTE_OFF_CAUSE 8'h10
`define IRTE_OFF_FAULT_VADDR 8'h14
`define IRTE_OFF_PT_CONTEXT 8'h18
`define IRTE_OFF_TLB_HI 8'h1C
`define IRTE_OFF_CACHE_ERR 8'h20
`define IRTE_OFF_ERROR_EPC 8'h24

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IRTE_CTL_APE 0
`define IRTE_CTL_ICE 1
`define IRTE_CTL_CLR 2
`define IRTE_CTL_STKDEC_LO 5
`define IRTE_ST_IE 0
`define IRTE_ST_EXL 1
`define IRTE_ST_ERL 2
`define IRTE_ST_KSU_LO 3
`define IRTE_ST_IPL_LO 10
`define IRTE_ST_BEV 22
`define IRTE_SRS_CSS_LO 0
`define IRTE_SRS_PSS_LO 6
`define IRTE_SRS_EICSS_LO 18
`define IRTE_SRS_HSS_LO 26
`define IRTE_REQUESTED_PRIORITY_LEVEL_LO 10
`define IRTE_CAUSE_IC 25

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IRTE_RST_INT_CTRL 32'h0000_0000
`define IRTE_RST_STATUS 32'h0040_0004
`define IRTE_RST_SRS_CTRL 32'h0000_0000

// ----------------------------------------------------------------------
// stack layout and register numbers
// ----------------------------------------------------------------------
`define IRTE_SP_IDX 5'h1D
`define IRTE_STK_EPC 32'h0000_0000
`define IRTE_STK_STATUS 32'h0000_0004
`define IRTE_STK_SRS 32'h0000_0008
`define IRTE_KSU_USER 2'h2

`endif

/* File: irte_pkg.sv */
/*
  types shared by the interrupt-return epilogue unit.
  assumes nothing beyond a systemverilog compiler.
*/
package irte_pkg;

  typedef enum logic [2:0] {
    MERR_NONE,
    MERR_TLB_REFILL,
    MERR_TLB_INVALID,
    MERR_CACHE,
    MERR_BUS,
    MERR_PRIV
  } irte_merr_e;

  typedef enum logic [2:0] {
    EXC_NONE,
    EXC_COP_UNUSABLE,
    EXC_RESERVED_INSTR,
    EXC_ADDR_ERR,
    EXC_TLB_REFILL,
    EXC_TLB_INVALID,
    EXC_CACHE_ERR,
    EXC_BUS_ERR
  } irte_exc_e;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] sp;
    logic user_mode;
    logic branch_slot;
    logic compact_isa;
  } irte_req_s;

  typedef struct packed {
    logic valid;
    logic redirect;
    logic [31:0] target;
    logic isa_mode;
    logic clear_hazards;
    logic kill_next;
    logic ll_clear;
    irte_exc_e exc;
  } irte_res_s;

  typedef struct packed {
    logic en;
    logic [3:0] set;
    logic [4:0] idx;
    logic [31:0] data;
  } irte_gpr_wr_s;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } irte_mem_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] data;
    irte_merr_e err;
  } irte_mem_rsp_s;

endpackage

/* File: irte_stack_rd.sv */
/*
  one stack word read: alignment check, then a held request to memory.
  assumes the memory answers each request with one ack cycle.
*/
`timescale 1ns/1ns
`include "irte_consts.svh"
module irte_stack_rd (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [31:0] addr,
  output irte_pkg::irte_mem_req_s mem_req,
  input irte_pkg::irte_mem_rsp_s mem_rsp,
  output logic done,
  output logic [31:0] rdata,
  output irte_pkg::irte_merr_e fault
);
  import irte_pkg::*;

  logic busy_reg;
  logic [31:0] addr_reg;
  logic done_reg;
  logic [31:0] rdata_reg;
  irte_merr_e fault_reg;
  wire misaligned = addr[1:0] != 2'h0;
  wire finish = busy_reg && mem_rsp.ack;

  assign mem_req.req = busy_reg;
  assign mem_req.addr = addr_reg;
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign fault = fault_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      fault_reg <= MERR_NONE;
    end else begin
      done_reg <= (go && misaligned) || finish;
      if (go) begin
        addr_reg <= addr;
        busy_reg <= !misaligned;
        fault_reg <= misaligned ? MERR_PRIV : MERR_NONE;
      end else if (finish) begin
        busy_reg <= 1'b0;
        rdata_reg <= mem_rsp.data;
        fault_reg <= mem_rsp.err;
      end
    end
  end
endmodule

/* File: irte_core.sv */
/*
  interrupt-return epilogue execution unit with its control registers on apb.
  assumes the pipeline pulses START with a request, waits for RESULT.valid,
  and that the interrupt controller pulses EIC_UPDATED after an accept.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
// Functional notes
// - auto-prologue off: behave as exception_return
// - error_level or bootstrap_vectors set: plain return
// - user mode raises coprocessor unusable
// - no chaining: disable, restore three words, bump
// - return: clear hazards, maybe copy set, resume
// - chaining: restore status first, compare priority
// - restored level higher: full restore and return
// - lower or equal: save sp, bump, accept next interrupt
// - load controller level and set, then copy
// - saved sp goes into new set
// - chain clears privilege and level fields optionally
// - chain: no barrier, jump to controller vector
// - no delay slot; next instruction killed
// - in branch slot raises reserved instruction
// - intervening return makes store_conditional fail
// - misaligned stack address raises address error
// - return resolves hazards from target fetch
// - stack reads report faults like word loads
// - save pc first, bit0 set in compact mode
// - status word read at sp plus four
// - set control at sp+8, pc at sp+0
// - frame size from decoded decrement field
// - copy previous set only under revision conditions
// - wait for controller update before sampling
// - clear level fields only when chain bit set
`timescale 1ns/1ns
`include "irte_consts.svh"
module irte_core #(
  parameter int ARCH_REV = 6
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic START,
  input irte_pkg::irte_req_s REQ,
  output logic BUSY,
  output irte_pkg::irte_res_s RESULT,
  output irte_pkg::irte_gpr_wr_s GPR_WR,
  output irte_pkg::irte_mem_req_s MEM_REQ,
  input irte_pkg::irte_mem_rsp_s MEM_RSP,
  input wire logic [7:0] EIC_RIPL,
  input wire logic [3:0] EIC_SS,
  input wire logic [31:0] EIC_VECTOR,
  input wire logic EIC_UPDATED,
  output logic EIC_ACCEPT,
  output logic [3:0] CUR_SHADOW_SET
);
  import irte_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_STATUS,
    ST_RD_SRS,
    ST_RD_EPC,
    ST_RETURN,
    ST_CHAIN_WAIT,
    ST_CHAIN_LOAD,
    ST_CHAIN_FINISH
  } irte_state_e;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  irte_state_e st_reg, st_next;
  logic [31:0] ctl_reg, ctl_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] srs_reg, srs_next;
  logic [31:0] epc_reg, epc_next;
  logic [31:0] errepc_reg, errepc_next;
  logic [31:0] cause_reg, cause_next;
  logic [31:0] fva_reg, fva_next;
  logic [31:0] ptc_reg, ptc_next;
  logic [31:0] tlbhi_reg, tlbhi_next;
  logic [31:0] cerr_reg, cerr_next;
  irte_req_s req_reg, req_next;
  logic [31:0] tmp_srs_reg, tmp_srs_next;
  logic [31:0] tmp29_reg, tmp29_next;
  irte_res_s res_reg, res_next;
  irte_gpr_wr_s gpr_reg, gpr_next;
  logic go_reg, go_next;
  logic [31:0] rd_addr_reg, rd_addr_next;
  logic accept_reg, accept_next;
  logic [31:0] prdata_reg;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  wire apb_setup = PSEL && !PENABLE;
  wire apb_access = PSEL && PENABLE;
  wire sel_ctl = PADDR == `IRTE_OFF_INT_CTRL;
  wire sel_status = PADDR == `IRTE_OFF_STATUS;
  wire sel_srs = PADDR == `IRTE_OFF_SRS_CTRL;
  wire sel_epc = PADDR == `IRTE_OFF_EPC;
  wire sel_cause = PADDR == `IRTE_OFF_CAUSE;
  wire sel_fva = PADDR == `IRTE_OFF_FAULT_VADDR;
  wire sel_ptc = PADDR == `IRTE_OFF_PT_CONTEXT;
  wire sel_tlbhi = PADDR == `IRTE_OFF_TLB_HI;
  wire sel_cerr = PADDR == `IRTE_OFF_CACHE_ERR;
  wire sel_errepc = PADDR == `IRTE_OFF_ERROR_EPC;
  wire mapped = sel_ctl || sel_status || sel_srs || sel_epc || sel_cause || sel_fva ||
                sel_ptc || sel_tlbhi || sel_cerr || sel_errepc;
  wire wr_en = apb_access && PWRITE && mapped;
  wire [31:0] rd_mux = sel_ctl ? ctl_reg :
                       sel_status ? status_reg :
                       sel_srs ? srs_reg :
                       sel_epc ? epc_reg :
                       sel_cause ? cause_reg :
                       sel_fva ? fva_reg :
                       sel_ptc ? ptc_reg :
                       sel_tlbhi ? tlbhi_reg :
                       sel_cerr ? cerr_reg :
                       sel_errepc ? errepc_reg : 32'h0000_0000;

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access && !mapped;

  // --------------------------------------------------------------------
  // field views
  // --------------------------------------------------------------------
  wire ape = ctl_reg[`IRTE_CTL_APE];
  wire ice = ctl_reg[`IRTE_CTL_ICE];
  wire clr_on_chain = ctl_reg[`IRTE_CTL_CLR];
  wire [4:0] stk_dec = ctl_reg[`IRTE_CTL_STKDEC_LO +: 5];
  wire [31:0] frame_bytes = {25'h000_0000, stk_dec, 2'b00};
  wire [31:0] sp_bumped = req_reg.sp + frame_bytes;
  wire st_erl = status_reg[`IRTE_ST_ERL];
  wire st_bev = status_reg[`IRTE_ST_BEV];
  wire [3:0] css = srs_reg[`IRTE_SRS_CSS_LO +: 4];
  wire plain_return = !ape || st_erl || st_bev;
  wire [31:0] saved_pc = REQ.compact_isa ? {REQ.pc[31:1], 1'b1} : REQ.pc;
  wire arch_ok = ARCH_REV >= 2;

  // stack read engine
  logic rd_done;
  logic [31:0] rd_data;
  irte_merr_e rd_fault;

  irte_stack_rd u_stack_rd (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .go(go_reg),
    .addr(rd_addr_reg),
    .mem_req(MEM_REQ),
    .mem_rsp(MEM_RSP),
    .done(rd_done),
    .rdata(rd_data),
    .fault(rd_fault)
  );

  wire rd_ok = rd_done && rd_fault == MERR_NONE;
  wire rd_bad = rd_done && rd_fault != MERR_NONE;
  wire [7:0] rd_ipl = rd_data[`IRTE_ST_IPL_LO +: 8];
  wire take_return = !ice || rd_ipl > EIC_RIPL;
  wire [3:0] rd_pss = rd_data[`IRTE_SRS_PSS_LO +: 4];
  wire rd_copy = rd_copy_hold(tmp_srs_reg, arch_ok, st_bev);
  wire exception_return_copy = arch_ok && srs_reg[`IRTE_SRS_HSS_LO +: 4] != 4'h0 && !st_bev;
  wire [31:0] exception_return_pc = st_erl ? errepc_reg : epc_reg;

  assign BUSY = st_reg != ST_IDLE;
  assign RESULT = res_reg;
  assign GPR_WR = gpr_reg;
  assign EIC_ACCEPT = accept_reg;
  assign CUR_SHADOW_SET = css;

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    ctl_next = (wr_en && sel_ctl) ? PWDATA : ctl_reg;
    status_next = (wr_en && sel_status) ? PWDATA : status_reg;
    srs_next = (wr_en && sel_srs) ? PWDATA : srs_reg;
    epc_next = (wr_en && sel_epc) ? PWDATA : epc_reg;
    errepc_next = (wr_en && sel_errepc) ? PWDATA : errepc_reg;
    cause_next = (wr_en && sel_cause) ? PWDATA : cause_reg;
    fva_next = fva_reg;
    ptc_next = ptc_reg;
    tlbhi_next = tlbhi_reg;
    cerr_next = cerr_reg;
    req_next = req_reg;
    tmp_srs_next = tmp_srs_reg;
    tmp29_next = tmp29_reg;
    res_next = '0;
    gpr_next = '0;
    go_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    accept_next = 1'b0;
    res_next.kill_next = 1'b1;
    unique case (st_reg)
      ST_IDLE: begin
        if (START) begin
          req_next = REQ;
          res_next.valid = 1'b1;
          if (REQ.user_mode) begin
            res_next.exc = EXC_COP_UNUSABLE;
          end else if (REQ.branch_slot) begin
            res_next.exc = EXC_RESERVED_INSTR;
          end else if (plain_return) begin
            res_next.redirect = 1'b1;
            res_next.target = REQ.compact_isa ? {exception_return_pc[31:1], 1'b0} : exception_return_pc;
            res_next.isa_mode = REQ.compact_isa && exception_return_pc[0];
            res_next.clear_hazards = 1'b1;
            res_next.ll_clear = 1'b1;
            if (st_erl) begin
              status_next[`IRTE_ST_ERL] = 1'b0;
            end else begin
              status_next[`IRTE_ST_EXL] = 1'b0;
              if (exception_return_copy) begin
                srs_next[`IRTE_SRS_CSS_LO +: 4] = srs_reg[`IRTE_SRS_PSS_LO +: 4];
              end
            end
          end else begin
            res_next.valid = 1'b0;
            epc_next = saved_pc;
            status_next[`IRTE_ST_IE] = 1'b0;
            go_next = 1'b1;
            rd_addr_next = REQ.sp + `IRTE_STK_STATUS;
            st_next = ST_RD_STATUS;
          end
        end
      end
      ST_RD_STATUS: begin
        if (rd_ok) begin
          status_next = rd_data;
          go_next = take_return;
          rd_addr_next = req_reg.sp + `IRTE_STK_SRS;
          st_next = take_return ? ST_RD_SRS : ST_CHAIN_WAIT;
          if (!take_return) begin
            tmp29_next = req_reg.sp;
            gpr_next = '{1'b1, css, `IRTE_SP_IDX, sp_bumped};
            accept_next = 1'b1;
          end
        end
      end
      ST_RD_SRS: begin
        if (rd_ok) begin
          tmp_srs_next = rd_data;
          go_next = 1'b1;
          rd_addr_next = req_reg.sp + `IRTE_STK_EPC;
          st_next = ST_RD_EPC;
        end
      end
      ST_RD_EPC: begin
        if (rd_ok) begin
          epc_next = rd_data;
          srs_next = tmp_srs_reg;
          if (rd_copy) begin
            srs_next[`IRTE_SRS_CSS_LO +: 4] = tmp_srs_reg[`IRTE_SRS_PSS_LO +: 4];
          end
          status_next[`IRTE_ST_EXL] = 1'b0;
          gpr_next = '{1'b1, css, `IRTE_SP_IDX, sp_bumped};
          st_next = ST_RETURN;
        end
      end
      ST_RETURN: begin
        res_next.valid = 1'b1;
        res_next.redirect = 1'b1;
        res_next.target = req_reg.compact_isa ? {epc_reg[31:1], 1'b0} : epc_reg;
        res_next.isa_mode = req_reg.compact_isa && epc_reg[0];
        res_next.clear_hazards = 1'b1;
        res_next.ll_clear = 1'b1;
        st_next = ST_IDLE;
      end
      ST_CHAIN_WAIT: begin
        if (EIC_UPDATED) begin
          cause_next[`IRTE_REQUESTED_PRIORITY_LEVEL_LO +: 8] = EIC_RIPL;
          srs_next[`IRTE_SRS_EICSS_LO +: 4] = EIC_SS;
          st_next = ST_CHAIN_LOAD;
        end
      end
      ST_CHAIN_LOAD: begin
        status_next[`IRTE_ST_IPL_LO +: 8] = cause_reg[`IRTE_REQUESTED_PRIORITY_LEVEL_LO +: 8];
        srs_next[`IRTE_SRS_CSS_LO +: 4] = srs_reg[`IRTE_SRS_EICSS_LO +: 4];
        if (clr_on_chain) begin
          status_next[`IRTE_ST_EXL] = 1'b0;
          status_next[`IRTE_ST_ERL] = 1'b0;
          status_next[`IRTE_ST_KSU_LO +: 2] = 2'h0;
        end
        cause_next[`IRTE_CAUSE_IC] = 1'b1;
        st_next = ST_CHAIN_FINISH;
      end
      ST_CHAIN_FINISH: begin
        gpr_next = '{1'b1, css, `IRTE_SP_IDX, tmp29_reg};
        res_next.valid = 1'b1;
        res_next.redirect = 1'b1;
        res_next.target = EIC_VECTOR;
        res_next.isa_mode = req_reg.compact_isa;
        res_next.clear_hazards = 1'b0;
        res_next.ll_clear = 1'b1;
        st_next = ST_IDLE;
      end
    endcase
    if (rd_bad && (st_reg == ST_RD_STATUS || st_reg == ST_RD_SRS || st_reg == ST_RD_EPC)) begin
      fva_next = (rd_fault == MERR_PRIV) ? rd_addr_reg : {rd_addr_reg[31:2], 2'b00};
      if (rd_fault == MERR_TLB_REFILL || rd_fault == MERR_TLB_INVALID) begin
        ptc_next = {rd_addr_reg[31:2], 2'b00};
        tlbhi_next = {rd_addr_reg[31:2], 2'b00};
      end
      if (rd_fault == MERR_CACHE) begin
        cerr_next = {rd_addr_reg[31:2], 2'b00};
      end
      res_next.valid = 1'b1;
      res_next.exc = exc_of(rd_fault);
      st_next = ST_IDLE;
    end
  end

  function automatic logic rd_copy_hold(input logic [31:0] w, input logic ok, input logic bev);
    rd_copy_hold = ok && w[`IRTE_SRS_HSS_LO +: 4] != 4'h0 && !bev;
  endfunction

  function automatic irte_exc_e exc_of(input irte_merr_e e);
    unique case (e)
      MERR_TLB_REFILL: exc_of = EXC_TLB_REFILL;
      MERR_TLB_INVALID: exc_of = EXC_TLB_INVALID;
      MERR_CACHE: exc_of = EXC_CACHE_ERR;
      MERR_BUS: exc_of = EXC_BUS_ERR;
      MERR_PRIV: exc_of = EXC_ADDR_ERR;
      default: exc_of = EXC_NONE;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_reg <= ST_IDLE;
      ctl_reg <= `IRTE_RST_INT_CTRL;
      status_reg <= `IRTE_RST_STATUS;
      srs_reg <= `IRTE_RST_SRS_CTRL;
      epc_reg <= 32'h0000_0000;
      errepc_reg <= 32'h0000_0000;
      cause_reg <= 32'h0000_0000;
      fva_reg <= 32'h0000_0000;
      ptc_reg <= 32'h0000_0000;
      tlbhi_reg <= 32'h0000_0000;
      cerr_reg <= 32'h0000_0000;
      req_reg <= '0;
      tmp_srs_reg <= 32'h0000_0000;
      tmp29_reg <= 32'h0000_0000;
      res_reg <= '0;
      gpr_reg <= '0;
      go_reg <= 1'b0;
      rd_addr_reg <= 32'h0000_0000;
      accept_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      ctl_reg <= ctl_next;
      status_reg <= status_next;
      srs_reg <= srs_next;
      epc_reg <= epc_next;
      errepc_reg <= errepc_next;
      cause_reg <= cause_next;
      fva_reg <= fva_next;
      ptc_reg <= ptc_next;
      tlbhi_reg <= tlbhi_next;
      cerr_reg <= cerr_next;
      req_reg <= req_next;
      tmp_srs_reg <= tmp_srs_next;
      tmp29_reg <= tmp29_next;
      res_reg <= res_next;
      gpr_reg <= gpr_next;
      go_reg <= go_next;
      rd_addr_reg <= rd_addr_next;
      accept_reg <= accept_next;
      if (apb_setup) begin
        prdata_reg <= rd_mux;
      end
    end
  end
endmodule

/* File: irte_core_asserts.sv */
/*
  concurrent checks on the ports of the epilogue unit.
  assumes one clock domain and a bind onto irte_core.
*/
`timescale 1ns/1ns
module irte_core_asserts (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PSLVERR,
  input wire logic START,
  input irte_pkg::irte_req_s REQ,
  input wire logic BUSY,
  input irte_pkg::irte_res_s RESULT,
  input irte_pkg::irte_gpr_wr_s GPR_WR,
  input irte_pkg::irte_mem_req_s MEM_REQ,
  input irte_pkg::irte_mem_rsp_s MEM_RSP,
  input wire logic [31:0] EIC_VECTOR,
  input wire logic EIC_UPDATED,
  input wire logic EIC_ACCEPT
);
  import irte_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // steps
  // ----
  sequence s_take;
    START && !BUSY;
  endsequence
  sequence s_chain_end;
    RESULT.valid && RESULT.target == EIC_VECTOR && !RESULT.clear_hazards;
  endsequence
  a_user_cop: assert property (s_take ##0 REQ.user_mode |=>
    RESULT.valid && RESULT.exc == EXC_COP_UNUSABLE) else $error("user mode not refused");
  a_slot_reserved: assert property (s_take ##0 !REQ.user_mode && REQ.branch_slot |=>
    RESULT.valid && RESULT.exc == EXC_RESERVED_INSTR) else $error("slot not refused");
  a_kill_next: assert property (RESULT.valid |-> RESULT.kill_next)
    else $error("next instruction not killed");
  a_stack_aligned: assert property (MEM_REQ.req |-> MEM_REQ.addr[1:0] == 2'h0)
    else $error("misaligned stack read issued");
  a_req_held: assert property (MEM_REQ.req && !MEM_RSP.ack |=>
    MEM_REQ.req && $stable(MEM_REQ.addr)) else $error("stack read dropped");
  a_accept_pulse: assert property (EIC_ACCEPT |=> !EIC_ACCEPT)
    else $error("accept longer than one cycle");
  a_wait_update: assert property (s_chain_end |-> $past(EIC_UPDATED, 3))
    else $error("result before controller update");
  a_chain_vector: assert property (EIC_ACCEPT |-> ##[1:40] s_chain_end)
    else $error("chain did not jump to vector");
  a_sp_index: assert property (GPR_WR.en |-> GPR_WR.idx == 5'h1D)
    else $error("stack pointer write to wrong register");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access phase");
endmodule

bind irte_core irte_core_asserts chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PSLVERR(PSLVERR), .START(START), .REQ(REQ), .BUSY(BUSY),
  .RESULT(RESULT), .GPR_WR(GPR_WR), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP),
  .EIC_VECTOR(EIC_VECTOR), .EIC_UPDATED(EIC_UPDATED), .EIC_ACCEPT(EIC_ACCEPT));

/* File: irte_eic_model.sv */
/*
  stack memory and interrupt controller model.
  assumes the bench fills mem and sets wait_n by hierarchy.
*/
`timescale 1ns/1ns
module irte_eic_model (
  input wire logic clk,
  input wire logic rst_n,
  input irte_pkg::irte_mem_req_s mem_req,
  output irte_pkg::irte_mem_rsp_s mem_rsp,
  input wire logic accept,
  input wire logic [7:0] base_lvl,
  output logic updated,
  output logic [7:0] ripl,
  output logic [3:0] ss,
  output logic [31:0] vector
);
  import irte_pkg::*;
  logic [31:0] mem [0:3];
  logic [7:0] cnt;
  logic [1:0] upd;
  int w;
  int wait_n = 0;
  assign ripl = base_lvl + cnt;
  assign ss = cnt[3:0] + 4'h5;
  assign vector = 32'h8000_0200;
  always @(posedge clk) begin
    mem_rsp.ack <= 1'h0;
    mem_rsp.err <= MERR_NONE;
    mem_rsp.data <= ~mem_rsp.data;
    updated <= 1'h0;
    if (!rst_n) begin
      mem_rsp.data <= 32'h5A5A_A5A5;
      w <= 0;
      upd <= 2'h0;
      cnt <= 8'h00;
    end else begin
      if (mem_req.req && !mem_rsp.ack) begin
        w <= w + 1;
        if (w >= wait_n) begin
          mem_rsp.ack <= 1'h1;
          mem_rsp.data <= mem[mem_req.addr[3:2]];
          w <= 0;
        end
      end
      if (accept) begin
        upd <= 2'h3;
      end else if (upd == 2'h1) begin
        cnt <= cnt + 8'h01;
        updated <= 1'h1;
        upd <= 2'h0;
      end else if (upd != 2'h0) begin
        upd <= upd - 2'h1;
      end
    end
  end
endmodule

/* File: tb_irte_core.sv */
/*
  self-checking bench for irte_core.
  assumes irte_eic_model as stack memory and interrupt controller.
*/
`timescale 1ns/1ns
module tb_irte_core;
  import irte_pkg::*;
  logic REF_CLK = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic START = 1'h0, PREADY, PSLVERR, BUSY, EIC_UPDATED, EIC_ACCEPT, er;
  logic [7:0] PADDR = 8'h00, EIC_RIPL, base_lvl = 8'h05;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, EIC_VECTOR, rd;
  logic [3:0] EIC_SS, CUR_SHADOW_SET;
  irte_req_s REQ = '0;
  irte_res_s RESULT, res;
  irte_gpr_wr_s GPR_WR, gw;
  irte_mem_req_s MEM_REQ;
  irte_mem_rsp_s MEM_RSP;
  int bad_count = 0, n_tests = 0, cyc = 0, n_ack = 0, n_acc = 0;
  irte_core dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .START(START), .REQ(REQ), .BUSY(BUSY), .RESULT(RESULT),
    .GPR_WR(GPR_WR), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP), .EIC_RIPL(EIC_RIPL),
    .EIC_SS(EIC_SS), .EIC_VECTOR(EIC_VECTOR), .EIC_UPDATED(EIC_UPDATED),
    .EIC_ACCEPT(EIC_ACCEPT), .CUR_SHADOW_SET(CUR_SHADOW_SET));
  irte_eic_model eic_u (.clk(REF_CLK), .rst_n(RST_N), .mem_req(MEM_REQ), .mem_rsp(MEM_RSP),
    .accept(EIC_ACCEPT), .base_lvl(base_lvl), .updated(EIC_UPDATED), .ripl(EIC_RIPL),
    .ss(EIC_SS), .vector(EIC_VECTOR));
  // ----
  // tasks
  // ----
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    @(posedge REF_CLK);
    while (PREADY !== 1'h1) @(posedge REF_CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task run(input logic [31:0] pc, input logic [31:0] sp, input logic u, b, c);
    @(posedge REF_CLK);
    START <= 1'h1;
    REQ <= '{pc, sp, u, b, c};
    @(posedge REF_CLK);
    START <= 1'h0;
    @(negedge REF_CLK);
    while (RESULT.valid !== 1'h1) @(negedge REF_CLK);
    res = RESULT;
    #1;
  endtask
  // ----
  // stimulus
  // ----
  initial forever #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  always @(negedge REF_CLK) begin
    if (GPR_WR.en === 1'h1) gw = GPR_WR;
    if (MEM_RSP.ack === 1'h1) n_ack++;
    if (EIC_ACCEPT === 1'h1) n_acc++;
  end
  initial begin
    eic_u.mem[0] = 32'h0000_3330;
    eic_u.mem[1] = 32'h0000_0C03;
    eic_u.mem[2] = 32'h0400_0080;
    repeat (5) @(posedge REF_CLK);
    RST_N <= 1'h1;
    apb(1'h0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0040_0004);
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk(32'(er), 32'h1);
    apb(1'h1, 8'h24, 32'h0000_4440);
    run(32'h0000_5550, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    chk(res.target, 32'h0000_4440);
    apb(1'h0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0040_0000);
    apb(1'h1, 8'h04, 32'h0000_0000);
    apb(1'h1, 8'h0C, 32'h0000_2220);
    run(32'h0000_5550, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    chk(res.target, 32'h0000_2220);
    chk(n_ack, 32'h0);
    for (int i = 0; i < 2; i++) begin
      run(32'h0000_5550, 32'h0000_1000, i == 0, 1'h1, 1'h0);
      chk(32'(res.exc), i == 0 ? 32'(EXC_COP_UNUSABLE) : 32'(EXC_RESERVED_INSTR));
    end
    $display("test plain done");
    eic_u.wait_n = 2;
    apb(1'h1, 8'h00, 32'h0000_0081);
    run(32'h0000_5550, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    chk(res.target, 32'h0000_3330);
    chk(32'({res.clear_hazards, res.ll_clear, res.kill_next}), 32'h7);
    chk(gw.data, 32'h0000_1010);
    chk(32'(CUR_SHADOW_SET), 32'h2);
    apb(1'h0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0C01);
    $display("test return done");
    eic_u.wait_n = 0;
    apb(1'h1, 8'h00, 32'h0000_0087);
    run(32'h0000_5550, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    chk(res.target, 32'h8000_0200);
    chk(32'(res.clear_hazards), 32'h0);
    chk(n_acc, 32'h1);
    chk({28'h0, gw.set}, 32'h6);
    chk(gw.data, 32'h0000_1000);
    chk(32'(CUR_SHADOW_SET), 32'h6);
    apb(1'h0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_1801);
    apb(1'h0, 8'h10, 32'h0000_0000);
    chk(rd & 32'h0203_FC00, 32'h0200_1800);
    base_lvl = 8'h01;
    run(32'h0000_5550, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    chk(res.target, 32'h0000_3330);
    chk(n_acc, 32'h1);
    base_lvl = 8'h05;
    apb(1'h1, 8'h00, 32'h0000_0083);
    run(32'h0000_5550, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    chk(n_acc, 32'h2);
    apb(1'h0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_1C03);
    $display("test chain done");
    apb(1'h1, 8'h00, 32'h0000_0081);
    run(32'h0000_5550, 32'h0000_1002, 1'h0, 1'h0, 1'h1);
    chk(32'(res.exc), 32'(EXC_ADDR_ERR));
    apb(1'h0, 8'h14, 32'h0000_0000);
    chk(rd, 32'h0000_1006);
    apb(1'h0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_5551);
    $display("test fault done");
    conclude();
  end
endmodule
